// ### cmbuf_store.sv
/*
  Message buffer store of a CAN controller: 32 buffers of eight 16-bit
  words held in shared RAM, a word port for software or DMA, frame
  assembly for transmit and frame write-back for receive.
  Assumes all inputs synchronous to ref_clk_in and a protocol engine
  that supplies received frames with buffer index and filter number.
*/
`default_nettype none

module cmbuf_store #(
  parameter int unsigned NUM_BUFFERS   = cmbuf_pkg::NUM_BUFFERS,
  parameter int unsigned RX_FIFO_DEPTH = cmbuf_pkg::RX_FIFO_DEPTH
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    reset_in,
  // Word port into the buffer memory
  input  wire logic [7:0]              mem_addr_in,
  input  wire logic                    mem_wr_in,
  input  wire logic [1:0]              mem_byte_en_in,
  input  wire logic [15:0]             mem_wdata_in,
  input  wire logic                    mem_rd_in,
  output logic [15:0]                  mem_rdata_out,
  output logic                         mem_rvalid_out,
  // Direction select, one bit per buffer
  input  wire logic [31:0]             buffer_direction_sel_in,
  // Transmit request and assembled frame
  input  wire logic                    tx_req_in,
  input  wire logic [4:0]              tx_buf_in,
  output logic                         tx_valid_out,
  output logic                         tx_refused_out,
  output cmbuf_pkg::cmbuf_frame_s      tx_frame_out,
  // Received frames from the protocol engine
  input  wire logic                    rx_valid_in,
  output logic                         rx_ready_out,
  input  wire cmbuf_pkg::cmbuf_rx_s    rx_frame_in,
  output logic                         rx_stored_out,
  output logic                         rx_dropped_out,
  output logic [4:0]                   rx_buf_out
);

  localparam int unsigned NUM_WORDS = NUM_BUFFERS * cmbuf_pkg::WORDS_PER_BUF;
  localparam int unsigned RX_WIDTH  = $bits(cmbuf_pkg::cmbuf_rx_s);

  // The address and index ports are sized for exactly 32 buffers
  if (NUM_BUFFERS != 32) begin : g_bad_buffers
    $error("cmbuf_store: NUM_BUFFERS must be 32");
  end
  if (RX_FIFO_DEPTH < 2) begin : g_bad_depth
    $error("cmbuf_store: RX_FIFO_DEPTH must be at least 2");
  end

  logic [15:0] mem [NUM_WORDS];

  // Receive path through the FIFO
  wire                      fifo_valid;
  wire                      fifo_ready;
  cmbuf_pkg::cmbuf_rx_s     fifo_data;
  wire                      drain_fire;
  wire                      drain_is_rx_buf;
  wire                      drain_store;
  wire                      drain_drop;
  logic [15:0]              rx_word [cmbuf_pkg::WORDS_PER_BUF];

  // Transmit assembly
  wire [7:0]                tx_base;
  wire                      tx_dir_ok;
  cmbuf_pkg::cmbuf_frame_s  next_tx_frame;
  logic [15:0]              tx_word [cmbuf_pkg::WORDS_PER_BUF];

  // Software write merge
  wire [15:0]               sw_be_mask;

  cmbuf_fifo #(
    .WIDTH (RX_WIDTH),
    .DEPTH (RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (rx_valid_in),
    .in_ready_out  (rx_ready_out),
    .in_data_in    (rx_frame_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_ready),
    .out_data_out  (fifo_data)
  );

  // Software writes own the memory port; a frame waits in the FIFO meanwhile
  assign fifo_ready      = !mem_wr_in;
  assign drain_fire      = fifo_valid && fifo_ready;
  assign drain_is_rx_buf = !buffer_direction_sel_in[fifo_data.buf_index];
  assign drain_store     = drain_fire && drain_is_rx_buf;
  assign drain_drop      = drain_fire && !drain_is_rx_buf;

  // Received frame packed into the buffer layout
  always_comb begin
    rx_word[cmbuf_pkg::SLOT_STD_IDENT] = '0;
    rx_word[cmbuf_pkg::SLOT_STD_IDENT][cmbuf_pkg::STD_IDENT_POS +: 11] = fifo_data.frame.std_ident;
    rx_word[cmbuf_pkg::SLOT_STD_IDENT][cmbuf_pkg::SUBST_REMOTE_POS] = fifo_data.frame.subst_remote_req;
    rx_word[cmbuf_pkg::SLOT_STD_IDENT][cmbuf_pkg::EXT_FORMAT_POS] = fifo_data.frame.extended_format_flag;
    rx_word[cmbuf_pkg::SLOT_EXT_IDENT] = '0;
    rx_word[cmbuf_pkg::SLOT_EXT_IDENT][cmbuf_pkg::EXT_HIGH_POS +: 12] = fifo_data.frame.ext_ident[17:6];
    rx_word[cmbuf_pkg::SLOT_LENGTH] = '0;
    rx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::EXT_LOW_POS +: 6] = fifo_data.frame.ext_ident[5:0];
    rx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::RTR_POS] = fifo_data.frame.rtr;
    rx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::RESERVED_ONE_POS] = fifo_data.frame.reserved_one;
    rx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::RESERVED_ZERO_POS] = fifo_data.frame.reserved_zero;
    rx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::DLC_POS +: 4] = fifo_data.frame.dlc;
    // Byte pairs, lower index in the low byte
    for (int k = 0; k < 4; k++) begin
      rx_word[3'(k + 3)] = {fifo_data.frame.payload_byte[2*k+1], fifo_data.frame.payload_byte[2*k]};
    end
    rx_word[cmbuf_pkg::SLOT_STATUS] = '0;
    rx_word[cmbuf_pkg::SLOT_STATUS][cmbuf_pkg::FILTER_HIT_POS +: 5] = fifo_data.filter_hit_code;
  end

  // Byte lanes of a software write
  assign sw_be_mask = {{8{mem_byte_en_in[1]}}, {8{mem_byte_en_in[0]}}};

  // One write port per word across all 32 buffers
  for (genvar e = 0; e < NUM_WORDS; e++) begin : g_word
    localparam logic [7:0] ADDR = 8'(e);
    localparam logic [2:0] SLOT = ADDR[2:0];
    localparam logic [15:0] MASK = cmbuf_pkg::cmbuf_slot_mask(SLOT);
    wire sw_hit;
    wire rx_hit;
    wire [15:0] next_word;

    assign sw_hit = mem_wr_in && (mem_addr_in == ADDR);
    assign rx_hit = drain_store && (fifo_data.buf_index == ADDR[7:3]);
    // Unimplemented bits never store, so they read zero once the word is written
    assign next_word = sw_hit ? (((mem_wdata_in & sw_be_mask) | (mem[e] & ~sw_be_mask)) & MASK)
                              : (rx_word[SLOT] & MASK);

    // Data words carry no reset: contents are unknown at power-up
    always_ff @(posedge ref_clk_in) begin
      if (sw_hit || rx_hit) mem[e] <= next_word;
    end
  end

  // Registered read port, one cycle latency
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_rdata_out  <= 16'h0000;
      mem_rvalid_out <= 1'b0;
    end else begin
      mem_rvalid_out <= mem_rd_in;
      if (mem_rd_in) mem_rdata_out <= mem[mem_addr_in];
    end
  end

  // Receive completion flags, registered at the same edge as the write
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_stored_out  <= 1'b0;
      rx_dropped_out <= 1'b0;
      rx_buf_out     <= 5'h00;
    end else begin
      rx_stored_out  <= drain_store;
      rx_dropped_out <= drain_drop;
      if (drain_fire) rx_buf_out <= fifo_data.buf_index;
    end
  end

  // Words of the buffer chosen for transmit
  assign tx_base   = {tx_buf_in, 3'h0};
  // Transmit only from a transmit buffer
  assign tx_dir_ok = buffer_direction_sel_in[tx_buf_in];

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      tx_word[k] = mem[tx_base | 8'(k)];
    end
  end

  always_comb begin
    next_tx_frame = '0;
    next_tx_frame.std_ident = tx_word[cmbuf_pkg::SLOT_STD_IDENT][cmbuf_pkg::STD_IDENT_POS +: 11];
    next_tx_frame.subst_remote_req = tx_word[cmbuf_pkg::SLOT_STD_IDENT][cmbuf_pkg::SUBST_REMOTE_POS];
    next_tx_frame.extended_format_flag = tx_word[cmbuf_pkg::SLOT_STD_IDENT][cmbuf_pkg::EXT_FORMAT_POS];
    next_tx_frame.ext_ident = {tx_word[cmbuf_pkg::SLOT_EXT_IDENT][cmbuf_pkg::EXT_HIGH_POS +: 12],
                               tx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::EXT_LOW_POS +: 6]};
    next_tx_frame.rtr = tx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::RTR_POS];
    // Reserved bits passed as software left them
    next_tx_frame.reserved_one  = tx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::RESERVED_ONE_POS];
    next_tx_frame.reserved_zero = tx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::RESERVED_ZERO_POS];
    next_tx_frame.dlc = tx_word[cmbuf_pkg::SLOT_LENGTH][cmbuf_pkg::DLC_POS +: 4];
    for (int k = 0; k < 4; k++) begin
      next_tx_frame.payload_byte[2*k]   = tx_word[3'(k + 3)][7:0];
      next_tx_frame.payload_byte[2*k+1] = tx_word[3'(k + 3)][15:8];
    end
  end

  // Frame register; a refused request leaves the last frame in place
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_frame_out   <= '0;
      tx_valid_out   <= 1'b0;
      tx_refused_out <= 1'b0;
    end else begin
      tx_valid_out   <= tx_req_in && tx_dir_ok;
      tx_refused_out <= tx_req_in && !tx_dir_ok;
      if (tx_req_in && tx_dir_ok) tx_frame_out <= next_tx_frame;
    end
  end

endmodule : cmbuf_store

`default_nettype wire

// ### cmbuf_pkg.sv
/*
  Shared layout of the message buffer store: word slots within a buffer,
  field positions, write masks and the frame carriers.
  Assumes a 16-bit buffer word and eight words per buffer.
*/
`default_nettype none

package cmbuf_pkg;

  // Geometry of the store
  localparam int unsigned NUM_BUFFERS   = 32;
  localparam int unsigned WORDS_PER_BUF = 8;
  localparam int unsigned PAYLOAD_BYTES = 8;
  localparam int unsigned RX_FIFO_DEPTH = 32;

  // Word slot within one buffer
  localparam logic [2:0] SLOT_STD_IDENT = 3'h0;
  localparam logic [2:0] SLOT_EXT_IDENT = 3'h1;
  localparam logic [2:0] SLOT_LENGTH    = 3'h2;
  localparam logic [2:0] SLOT_PAYLOAD0  = 3'h3;
  localparam logic [2:0] SLOT_STATUS    = 3'h7;

  // Field positions (least significant bit of each field)
  localparam int unsigned STD_IDENT_POS    = 2;
  localparam int unsigned SUBST_REMOTE_POS = 1;
  localparam int unsigned EXT_FORMAT_POS   = 0;
  localparam int unsigned EXT_HIGH_POS     = 0;
  localparam int unsigned EXT_LOW_POS      = 10;
  localparam int unsigned RTR_POS          = 9;
  localparam int unsigned RESERVED_ONE_POS = 8;
  localparam int unsigned RESERVED_ZERO_POS = 4;
  localparam int unsigned DLC_POS          = 0;
  localparam int unsigned FILTER_HIT_POS   = 8;

  // Implemented bits per slot; the rest read as zero once the word is written
  localparam logic [15:0] MASK_STD_IDENT = 16'h1FFF;
  localparam logic [15:0] MASK_EXT_IDENT = 16'h0FFF;
  localparam logic [15:0] MASK_LENGTH    = 16'hFF1F;
  localparam logic [15:0] MASK_PAYLOAD   = 16'hFFFF;
  localparam logic [15:0] MASK_STATUS    = 16'h1F00;

  function automatic logic [15:0] cmbuf_slot_mask(input logic [2:0] slot);
    logic [15:0] m;
    m = MASK_PAYLOAD;
    if (slot == SLOT_STD_IDENT) m = MASK_STD_IDENT;
    if (slot == SLOT_EXT_IDENT) m = MASK_EXT_IDENT;
    if (slot == SLOT_LENGTH)    m = MASK_LENGTH;
    if (slot == SLOT_STATUS)    m = MASK_STATUS;
    return m;
  endfunction : cmbuf_slot_mask

  // One CAN frame as the controller sees it
  typedef struct packed {
    logic [10:0]     std_ident;
    logic [17:0]     ext_ident;
    logic            subst_remote_req;
    logic            extended_format_flag;
    logic            rtr;
    logic            reserved_one;
    logic            reserved_zero;
    logic [3:0]      dlc;
    logic [7:0][7:0] payload_byte;
  } cmbuf_frame_s;

  // A received frame with its target buffer and the filter that took it
  typedef struct packed {
    logic [4:0]   buf_index;
    logic [4:0]   filter_hit_code;
    cmbuf_frame_s frame;
  } cmbuf_rx_s;

endpackage : cmbuf_pkg

`default_nettype wire

// ### cmbuf_fifo.sv
/*
  Synchronous FIFO of flip-flops with valid/ready on both sides.
  Assumes one clock; depth a power of two, at least two.
*/
`default_nettype none

module cmbuf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int unsigned AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_params
    $error("cmbuf_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              push;
  wire              pop;
  wire              empty;
  wire              full;

  // Extra pointer bit tells full from empty
  assign empty         = (wr_ptr == rd_ptr);
  assign full          = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;
  assign out_data_out  = store[rd_ptr[AW-1:0]];

  // Pointers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage needs no reset; empty hides stale words
  always_ff @(posedge ref_clk_in) begin
    if (push) store[wr_ptr[AW-1:0]] <= in_data_in;
  end

endmodule : cmbuf_fifo

`default_nettype wire

// ### cmbuf_store_checker.sv
/*
  Port checker for the message buffer store.
  Assumes it is bound onto every cmbuf_store instance.
*/
`default_nettype none

module cmbuf_store_checker #(
  parameter int unsigned NUM_BUFFERS   = 32,
  parameter int unsigned RX_FIFO_DEPTH = 32
) (
  input wire logic                    ref_clk_in,
  input wire logic                    reset_in,
  input wire logic [7:0]              mem_addr_in,
  input wire logic                    mem_wr_in,
  input wire logic                    mem_rd_in,
  input wire logic [15:0]             mem_rdata_out,
  input wire logic                    mem_rvalid_out,
  input wire logic [31:0]             buffer_direction_sel_in,
  input wire logic                    tx_req_in,
  input wire logic [4:0]              tx_buf_in,
  input wire logic                    tx_valid_out,
  input wire logic                    tx_refused_out,
  input wire cmbuf_pkg::cmbuf_frame_s tx_frame_out,
  input wire logic                    rx_stored_out,
  input wire logic                    rx_dropped_out,
  input wire logic [4:0]              rx_buf_out
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  // Read answers come exactly one cycle after the strobe
  a_read_pulse: assert property (mem_rd_in |=> mem_rvalid_out)
    else $error("read strobe without answer");
  a_read_quiet: assert property (!mem_rd_in |=> !mem_rvalid_out && $stable(mem_rdata_out))
    else $error("read data moved without a read");
  // Unimplemented bits read as zero once the word is written
  a_std_unimpl: assert property (mem_rd_in && mem_addr_in[2:0] == 3'h0 |=> mem_rdata_out[15:13] == 3'h0)
    else $error("identifier word top bits not zero");
  a_ext_unimpl: assert property (mem_rd_in && mem_addr_in[2:0] == 3'h1 |=> mem_rdata_out[15:12] == 4'h0)
    else $error("extended word top bits not zero");
  a_len_unimpl: assert property (mem_rd_in && mem_addr_in[2:0] == 3'h2 |=> mem_rdata_out[7:5] == 3'h0)
    else $error("length word bits 7..5 not zero");
  a_stat_unimpl: assert property (mem_rd_in && mem_addr_in[2:0] == 3'h7 |=> (mem_rdata_out & 16'hE0FF) == 16'h0)
    else $error("status word outside filter field not zero");
  // Transmit answers follow the direction bit
  a_tx_accept: assert property (tx_req_in && buffer_direction_sel_in[tx_buf_in] |=> tx_valid_out && !tx_refused_out)
    else $error("transmit buffer request not accepted");
  a_tx_refuse: assert property (tx_req_in && !buffer_direction_sel_in[tx_buf_in]
    |=> tx_refused_out && !tx_valid_out && $stable(tx_frame_out))
    else $error("receive buffer request not refused");
  a_tx_quiet: assert property (!tx_req_in |=> !tx_valid_out && !tx_refused_out && $stable(tx_frame_out))
    else $error("transmit outputs moved without request");
  // Receive results agree with the target direction and never take a software write cycle
  a_rx_dir: assert property (rx_stored_out |-> !buffer_direction_sel_in[rx_buf_out] && !rx_dropped_out)
    else $error("frame stored into a transmit buffer");
  a_rx_drop: assert property (rx_dropped_out |-> buffer_direction_sel_in[rx_buf_out])
    else $error("frame dropped for a receive buffer");
  a_rx_no_stall: assert property (rx_stored_out || rx_dropped_out |-> !$past(mem_wr_in))
    else $error("drain took the port from a software write");
endmodule : cmbuf_store_checker

bind cmbuf_store cmbuf_store_checker #(
  .NUM_BUFFERS(NUM_BUFFERS), .RX_FIFO_DEPTH(RX_FIFO_DEPTH)
) u_cmbuf_store_checker (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .mem_addr_in(mem_addr_in),
  .mem_wr_in(mem_wr_in), .mem_rd_in(mem_rd_in), .mem_rdata_out(mem_rdata_out),
  .mem_rvalid_out(mem_rvalid_out), .buffer_direction_sel_in(buffer_direction_sel_in),
  .tx_req_in(tx_req_in), .tx_buf_in(tx_buf_in), .tx_valid_out(tx_valid_out),
  .tx_refused_out(tx_refused_out), .tx_frame_out(tx_frame_out), .rx_stored_out(rx_stored_out),
  .rx_dropped_out(rx_dropped_out), .rx_buf_out(rx_buf_out)
);

`default_nettype wire

// ### cmbuf_engine_model.sv
/*
  Protocol engine stand-in: offers received frames on valid/ready.
  Assumes the bench queues frames through the send task.
*/
`default_nettype none

module cmbuf_engine_model (
  input  wire logic                 ref_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 slow_in,
  input  wire logic                 rx_ready_in,
  output logic                      rx_valid_out,
  output cmbuf_pkg::cmbuf_rx_s      rx_frame_out
);
  timeunit 1ns;
  timeprecision 1ps;
  cmbuf_pkg::cmbuf_rx_s q[$];
  logic                 gap;
  logic                 tk;

  task automatic send(input cmbuf_pkg::cmbuf_rx_s f);
    q.push_back(f);
  endtask : send

  initial begin
    rx_valid_out = 1'b0;
    rx_frame_out = '0;
    gap = 1'b0;
  end

  always @(posedge ref_clk_in) begin
    tk = rx_valid_out && rx_ready_in;
    #1;
    if (tk) void'(q.pop_front());
    if (!rx_valid_out || tk) begin
      gap = slow_in && !gap;
      rx_valid_out = (q.size() != 0) && !gap && !reset_in;
    end
    // Idle bus shows the bus inverted each cycle, so every other idle cycle shows the last frame
    if (rx_valid_out) rx_frame_out = q[0];
    else rx_frame_out = ~rx_frame_out;
  end
endmodule : cmbuf_engine_model

`default_nettype wire

// ### tb.sv
/*
  Self-checking bench for the message buffer store with a memory model.
  Assumes cmbuf_store, its checker and the engine model are compiled.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    ref_clk_in, reset_in, mem_wr_in, mem_rd_in, tx_req_in, slow;
  logic                    rx_valid_in, rx_ready_out, mem_rvalid_out, tx_valid_out;
  logic                    tx_refused_out, rx_stored_out, rx_dropped_out;
  logic [7:0]              mem_addr_in;
  logic [1:0]              mem_byte_en_in;
  logic [15:0]             mem_wdata_in, mem_rdata_out;
  logic [31:0]             dir;
  logic [4:0]              tx_buf_in, rx_buf_out;
  logic [127:0]            rnd;
  cmbuf_pkg::cmbuf_frame_s tx_frame_out, fexp;
  cmbuf_pkg::cmbuf_rx_s    rx_frame_in, rc, rq[$];
  logic [15:0]             mdl[256] = '{default: 16'h0};
  int                      n_mismatch = 0, checks = 0, seed = 85198;

  cmbuf_store u_cmbuf_store (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .mem_addr_in(mem_addr_in),
    .mem_wr_in(mem_wr_in), .mem_byte_en_in(mem_byte_en_in), .mem_wdata_in(mem_wdata_in),
    .mem_rd_in(mem_rd_in), .mem_rdata_out(mem_rdata_out), .mem_rvalid_out(mem_rvalid_out),
    .buffer_direction_sel_in(dir), .tx_req_in(tx_req_in), .tx_buf_in(tx_buf_in),
    .tx_valid_out(tx_valid_out), .tx_refused_out(tx_refused_out), .tx_frame_out(tx_frame_out),
    .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .rx_frame_in(rx_frame_in),
    .rx_stored_out(rx_stored_out), .rx_dropped_out(rx_dropped_out), .rx_buf_out(rx_buf_out));
  cmbuf_engine_model u_cmbuf_engine_model (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .slow_in(slow),
    .rx_ready_in(rx_ready_out), .rx_valid_out(rx_valid_in), .rx_frame_out(rx_frame_in));

  initial ref_clk_in = 1'b0;
  always #20 ref_clk_in = ~ref_clk_in;

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Implemented bits of each slot
  function automatic logic [15:0] msk(input logic [2:0] s);
    case (s)
      3'h0: return 16'h1FFF;
      3'h1: return 16'h0FFF;
      3'h2: return 16'hFF1F;
      3'h7: return 16'h1F00;
      default: return 16'hFFFF;
    endcase
  endfunction : msk

  // Word image of a received frame
  function automatic logic [15:0] wv(input cmbuf_pkg::cmbuf_rx_s r, input int s);
    cmbuf_pkg::cmbuf_frame_s f;
    f = r.frame;
    case (s)
      0: return {3'h0, f.std_ident, f.subst_remote_req, f.extended_format_flag};
      1: return {4'h0, f.ext_ident[17:6]};
      2: return {f.ext_ident[5:0], f.rtr, f.reserved_one, 3'h0, f.reserved_zero, f.dlc};
      7: return {3'h0, r.filter_hit_code, 8'h00};
      default: return {f.payload_byte[2*s-5], f.payload_byte[2*s-6]};
    endcase
  endfunction : wv

  // Frame assembled from the model's buffer words
  function automatic cmbuf_pkg::cmbuf_frame_s fr(input logic [4:0] b);
    cmbuf_pkg::cmbuf_frame_s f;
    logic [15:0]             w[8];
    for (int s = 0; s < 8; s++) w[s] = mdl[{b, s[2:0]}];
    f.std_ident = w[0][12:2];
    f.subst_remote_req = w[0][1];
    f.extended_format_flag = w[0][0];
    f.ext_ident = {w[1][11:0], w[2][15:10]};
    f.rtr = w[2][9];
    f.reserved_one = w[2][8];
    f.reserved_zero = w[2][4];
    f.dlc = w[2][3:0];
    for (int k = 0; k < 8; k++) f.payload_byte[k] = w[3+k/2][8*(k%2)+:8];
    return f;
  endfunction : fr

  // Write leaves the strobe up; the caller drops it
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] m;
    if (a[2:0] == 3'h2) d = d & 16'hFEEF;
    m = {{8{be[1]}}, {8{be[0]}}} & msk(a[2:0]);
    mdl[a] = (mdl[a] & ~m) | (d & m);
    mem_addr_in = a;
    mem_wdata_in = d;
    mem_byte_en_in = be;
    mem_wr_in = 1'b1;
    @(posedge ref_clk_in) #1;
  endtask : wr

  task automatic readback();
    for (int i = 0; i < 256; i++) begin
      mem_addr_in = i[7:0];
      mem_rd_in = 1'b1;
      @(posedge ref_clk_in) #1;
      chk(mem_rvalid_out, 1'b1);
      chk(mem_rdata_out, mdl[i]);
    end
    mem_rd_in = 1'b0;
  endtask : readback

  task automatic push_frames(input int n);
    for (int i = 0; i < n; i++) begin
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      rc = rnd[111:0];
      rq.push_back(rc);
      u_cmbuf_engine_model.send(rc);
    end
  endtask : push_frames

  task automatic wait_drain();
    for (int t = 0; t < 400 && rq.size() != 0; t++) @(posedge ref_clk_in);
    chk(rq.size(), 0);
    @(posedge ref_clk_in) #1;
  endtask : wait_drain

  // Drain pulses are matched against the oldest frame sent
  always @(negedge ref_clk_in) begin
    if (!reset_in && (rx_stored_out || rx_dropped_out) && rq.size() != 0) begin
      rc = rq.pop_front();
      chk({rx_stored_out, rx_dropped_out, rx_buf_out}, {~dir[rc.buf_index], dir[rc.buf_index], rc.buf_index});
      if (!dir[rc.buf_index]) for (int s = 0; s < 8; s++) mdl[{rc.buf_index, s[2:0]}] = wv(rc, s);
    end
  end

  // Hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {reset_in, mem_wr_in, mem_rd_in, tx_req_in, slow} = 5'h10;
    {mem_addr_in, mem_byte_en_in, mem_wdata_in, tx_buf_in} = '0;
    fexp = '0;
    dir = $random(seed) | 32'h80000000;
    repeat (16) @(posedge ref_clk_in);
    #1 reset_in = 1'b0;
    chk({tx_valid_out, tx_refused_out, rx_stored_out, rx_dropped_out, mem_rvalid_out, rx_ready_out}, 6'h01);
    $display("test reset done");
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 256; i++) wr(i[7:0], 16'($random(seed)), (p == 0) ? 2'h3 : 2'($random(seed)));
    mem_wr_in = 1'b0;
    readback();
    $display("test layout done");
    for (int b = 0; b < 32; b++) begin
      tx_buf_in = b[4:0];
      tx_req_in = 1'b1;
      @(posedge ref_clk_in) #1;
      chk({tx_valid_out, tx_refused_out}, {dir[b], ~dir[b]});
      if (dir[b]) fexp = fr(b[4:0]);
      chk(tx_frame_out, fexp);
    end
    tx_req_in = 1'b0;
    $display("test transmit done");
    slow = 1'b1;
    push_frames(12);
    wait_drain();
    readback();
    $display("test receive done");
    slow = 1'b0;
    wr(8'hFB, 16'h1234, 2'h3);
    push_frames(33);
    for (int t = 0; t < 100 && rx_ready_out; t++) @(posedge ref_clk_in) #1;
    // Model drops its last taken frame at this same instant; look mid-cycle
    @(negedge ref_clk_in);
    chk({rx_ready_out, 6'(u_cmbuf_engine_model.q.size())}, 7'h01);
    @(posedge ref_clk_in) #1;
    mem_wr_in = 1'b0;
    wait_drain();
    readback();
    $display("test fifo fill done");
    print_verdict();
  end
endmodule : tb

`default_nettype wire
